// ---- src/ussr_register.sv ----
`timescale 1ns/1ps

// **********************************************************************
// Load log buffer.
// **********************************************************************
module ussr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned PTR_W = 3,
  parameter int unsigned CNT_W = 4
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side.
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side.
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
  assign in_ready   = (count_reg != CNT_W'(DEPTH));
  assign out_valid  = (count_reg != '0);
  assign out_data   = mem_reg[rd_ptr_reg];

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_reg[i] <= '0;
        end else if (push && (wr_ptr_reg == PTR_W'(i))) begin
          mem_reg[i] <= in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + PTR_W'(1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_reg + PTR_W'(1) : rd_ptr_reg;
      count_reg  <= count_next;
    end
  end

endmodule

// **********************************************************************
// Universal shift and storage register.
// **********************************************************************
module ussr_register (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Mode and output control.
  input  wire logic       mode_select_low,
  input  wire logic       mode_select_high,
  input  wire logic       port_drive_disable_a,
  input  wire logic       port_drive_disable_b,
  input  wire logic       sync_clear_n,
  // Serial cascade.
  input  wire logic       right_serial_in,
  input  wire logic       left_serial_in,
  output logic            first_bit_serial_out,
  output logic            last_bit_serial_out,
  // Shared parallel ports.
  input  wire logic [7:0] stored_bits_in,
  output logic [7:0]      stored_bits_out,
  output logic [7:0]      stored_bits_oe,
  // Load log stream.
  output logic            load_log_ready,
  output logic            load_log_valid,
  output logic [7:0]      load_log_data,
  input  wire logic       load_log_take
);

  ussr_pkg::ussr_mode_type mode;
  logic [7:0] stored_reg;
  logic [7:0] stored_next;
  logic       oe_next;
  logic       first_reg;
  logic       last_reg;
  logic       log_push;

  // ********************************************************************
  // Mode decode and next word.
  // ********************************************************************
  assign mode = ussr_pkg::ussr_mode_type'({mode_select_high, mode_select_low});

  assign stored_next =
    !sync_clear_n                     ? ussr_pkg::WORD_RESET :
    (mode == ussr_pkg::MODE_RIGHT)    ? {stored_reg[6:0], right_serial_in} :
    (mode == ussr_pkg::MODE_LEFT)     ? {left_serial_in, stored_reg[7:1]} :
    (mode == ussr_pkg::MODE_LOAD)     ? stored_bits_in :
    stored_reg;

  // Drivers follow the selects and controls in the same cycle.
  // A registered enable would still drive during the first load cycle.
  // The load would then capture the register's own outputs.
  assign oe_next = rst_n && (mode != ussr_pkg::MODE_LOAD) && !port_drive_disable_a &&
                   !port_drive_disable_b;

  assign log_push = sync_clear_n && (mode == ussr_pkg::MODE_LOAD);

  // ********************************************************************
  // Storage flops.
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_reg <= ussr_pkg::WORD_RESET;
      first_reg  <= 1'b0;
      last_reg   <= 1'b0;
    end else begin
      stored_reg <= stored_next;
      first_reg  <= stored_next[ussr_pkg::FIRST_BIT];
      last_reg   <= stored_next[ussr_pkg::LAST_BIT];
    end
  end

  assign stored_bits_out      = stored_reg;
  assign stored_bits_oe       = {8{oe_next}};
  assign first_bit_serial_out = first_reg;
  assign last_bit_serial_out  = last_reg;

  // ********************************************************************
  // Load log buffer.
  // ********************************************************************
  ussr_fifo #(
    .WIDTH (ussr_pkg::WORD_WIDTH),
    .DEPTH (ussr_pkg::LOG_DEPTH),
    .PTR_W (ussr_pkg::LOG_PTR_W),
    .CNT_W (ussr_pkg::LOG_CNT_W)
  ) u_log (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (log_push),
    .in_data   (stored_bits_in),
    .in_ready  (load_log_ready),
    .out_valid (load_log_valid),
    .out_data  (load_log_data),
    .out_ready (load_log_take)
  );

  // ********************************************************************
  // Checks.
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_load;
    $past(sync_clear_n) && ($past(mode) == ussr_pkg::MODE_LOAD)
      |-> stored_bits_out == $past(stored_bits_in);
  endproperty
  a_load: assert property (p_load) else $error("Load lost port data.");

  property p_right;
    $past(sync_clear_n) && ($past(mode) == ussr_pkg::MODE_RIGHT)
      |-> stored_bits_out == {$past(stored_reg[6:0]), $past(right_serial_in)};
  endproperty
  a_right: assert property (p_right) else $error("Right shift wrong.");

  property p_left;
    $past(sync_clear_n) && ($past(mode) == ussr_pkg::MODE_LEFT)
      |-> stored_bits_out == {$past(left_serial_in), $past(stored_reg[7:1])};
  endproperty
  a_left: assert property (p_left) else $error("Left shift wrong.");

  property p_hold;
    sync_clear_n && (mode == ussr_pkg::MODE_HOLD) |=> $stable(stored_bits_out);
  endproperty
  a_hold: assert property (p_hold) else $error("Hold changed the word.");

  property p_clear;
    !sync_clear_n |=> (stored_bits_out == ussr_pkg::WORD_RESET) &&
      !first_bit_serial_out && !last_bit_serial_out;
  endproperty
  a_clear: assert property (p_clear) else $error("Clear did not zero.");

  property p_load_hiz;
    mode == ussr_pkg::MODE_LOAD |-> stored_bits_oe == 8'h00;
  endproperty
  a_load_hiz: assert property (p_load_hiz) else $error("Driving during load.");

  property p_gate_hiz;
    (port_drive_disable_a || port_drive_disable_b) |-> stored_bits_oe == 8'h00;
  endproperty
  a_gate_hiz: assert property (p_gate_hiz) else $error("Driving while gated.");

  property p_drive;
    (mode != ussr_pkg::MODE_LOAD) && !port_drive_disable_a && !port_drive_disable_b
      |-> stored_bits_oe == 8'hFF;
  endproperty
  a_drive: assert property (p_drive) else $error("Drivers not enabled.");

  property p_serial;
    (first_bit_serial_out == stored_bits_out[ussr_pkg::FIRST_BIT]) &&
    (last_bit_serial_out == stored_bits_out[ussr_pkg::LAST_BIT]);
  endproperty
  a_serial: assert property (p_serial) else $error("Serial out mismatch.");

  property p_log;
    log_push && load_log_ready |=> load_log_valid;
  endproperty
  a_log: assert property (p_log) else $error("Load not logged.");

  c_load:  cover property (sync_clear_n && mode == ussr_pkg::MODE_LOAD);
  c_shift: cover property (mode == ussr_pkg::MODE_RIGHT ##1 mode == ussr_pkg::MODE_LEFT);
  c_full:  cover property (!load_log_ready);
  c_clear_load: cover property (!sync_clear_n && mode == ussr_pkg::MODE_LOAD);

endmodule

// ---- common/ussr_pkg.sv ----
package ussr_pkg;

  // ********************************************************************
  // Word and storage layout.
  // ********************************************************************
  localparam int unsigned WORD_WIDTH = 8;
  localparam int unsigned FIRST_BIT  = 0;
  localparam int unsigned LAST_BIT   = 7;
  localparam logic [7:0]  WORD_RESET = 8'h00;

  // ********************************************************************
  // Load log buffer layout.
  // ********************************************************************
  localparam int unsigned LOG_DEPTH  = 8;
  localparam int unsigned LOG_PTR_W  = 3;
  localparam int unsigned LOG_CNT_W  = 4;

  // ********************************************************************
  // Operating modes, coded as {mode_select_high, mode_select_low}.
  // ********************************************************************
  typedef enum logic [1:0] {
    MODE_HOLD  = 2'b00,
    MODE_RIGHT = 2'b01,
    MODE_LEFT  = 2'b10,
    MODE_LOAD  = 2'b11
  } ussr_mode_type;

endpackage

// ---- tb/ussr_bus_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Parallel bus master model.
// ****************************************************************
module ussr_bus_model (
  // Clock.
  input  wire logic       clk,
  // Device side of the shared lines.
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  output logic [7:0]      pins,
  // Bus master drive.
  input  wire logic       drv_en,
  input  wire logic [7:0] drv_val
);
  logic [7:0] float_reg;

  initial float_reg = 8'h00;

  // Undriven lines 0, 1, 6 and 7 toggle every cycle; lines 2 to 5 stay low.
  always @(posedge clk) float_reg <= ~float_reg ^ 8'h3C;

  // Drive load data only while the device lets go.
  assign pins = (dev_oe & dev_out) | (~dev_oe & (drv_en ? drv_val : float_reg));
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Top level bench.
// ****************************************************************
module testbench;
  logic       clk, rst_n, clr_n, rsi, lsi, take, drv_en, fbo, lbo, lrdy, lval;
  logic [1:0] mode, gate;
  logic [7:0] drv_val, pins, q, oe, ldat;
  int         miscompares, tests_run, i;

  ussr_register ussr_register_inst (
    .clk(clk), .rst_n(rst_n), .mode_select_low(mode[0]), .mode_select_high(mode[1]),
    .port_drive_disable_a(gate[0]), .port_drive_disable_b(gate[1]), .sync_clear_n(clr_n),
    .right_serial_in(rsi), .left_serial_in(lsi), .first_bit_serial_out(fbo),
    .last_bit_serial_out(lbo), .stored_bits_in(pins), .stored_bits_out(q),
    .stored_bits_oe(oe), .load_log_ready(lrdy), .load_log_valid(lval),
    .load_log_data(ldat), .load_log_take(take));

  ussr_bus_model ussr_bus_model_inst (
    .clk(clk), .dev_out(q), .dev_oe(oe), .pins(pins), .drv_en(drv_en), .drv_val(drv_val));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One clock of the given mode; serial bits ride on d[0] and d[7].
  task automatic op(input logic [1:0] m, input logic [1:0] g, input logic c, input logic [7:0] d);
    mode    = m;
    gate    = g;
    clr_n   = c;
    drv_en  = (m == 2'b11);
    drv_val = d;
    rsi     = d[0];
    lsi     = d[7];
    @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    rst_n   = 1'b0;
    mode    = 2'b00;
    gate    = 2'b00;
    clr_n   = 1'b1;
    rsi     = 1'b0;
    lsi     = 1'b0;
    take    = 1'b0;
    drv_en  = 1'b0;
    drv_val = 8'h00;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("word", q, 8'h00);
    check("oe", oe, 8'h00);
    check("flags", {6'h00, lrdy, lval}, 8'h02);
    rst_n = 1'b1;
    $display("test reset done");
    op(2'b11, 2'b00, 1'b1, 8'hA5);
    check("word", q, 8'hA5);
    check("oe", oe, 8'h00);
    check("serial", {6'h00, lbo, fbo}, 8'h03);
    check("log", ldat, 8'hA5);
    op(2'b00, 2'b00, 1'b1, 8'h00);
    check("oe", oe, 8'hFF);
    check("pins", pins, 8'hA5);
    $display("test load done");
    op(2'b01, 2'b00, 1'b1, 8'h00);
    check("word", q, 8'h4A);
    check("serial", {6'h00, lbo, fbo}, 8'h00);
    op(2'b01, 2'b10, 1'b1, 8'h01);
    check("word", q, 8'h95);
    check("oe", oe, 8'h00);
    op(2'b10, 2'b01, 1'b1, 8'h80);
    check("word", q, 8'hCA);
    check("serial", {6'h00, lbo, fbo}, 8'h02);
    op(2'b10, 2'b00, 1'b1, 8'h00);
    check("word", q, 8'h65);
    check("pins", pins, 8'h65);
    $display("test shift done");
    op(2'b01, 2'b00, 1'b0, 8'h01);
    check("word", q, 8'h00);
    op(2'b11, 2'b00, 1'b0, 8'h3C);
    check("word", q, 8'h00);
    check("log", {lval, ldat[6:0]}, 8'hA5);
    take = 1'b1;
    op(2'b00, 2'b11, 1'b1, 8'h00);
    take = 1'b0;
    check("valid", {7'h00, lval}, 8'h00);
    $display("test clear done");
    for (i = 0; i < 9; i++) begin
      op(2'b11, 2'b11, 1'b1, 8'h10 + 8'(i));
    end
    check("word", q, 8'h18);
    check("ready", {7'h00, lrdy}, 8'h00);
    op(2'b00, 2'b11, 1'b1, 8'h00);
    take = 1'b1;
    for (i = 0; i < 8; i++) begin
      check("log", ldat, 8'h10 + 8'(i));
      @(negedge clk);
    end
    take = 1'b0;
    check("flags", {6'h00, lrdy, lval}, 8'h02);
    $display("test log done");
    op(2'b00, 2'b00, 1'b1, 8'h00);
    check("pins", pins, 8'h18);
    op(2'b11, 2'b00, 1'b1, 8'hC3);
    check("word", q, 8'hC3);
    check("oe", oe, 8'h00);
    check("log", ldat, 8'hC3);
    $display("test isolate done");
    give_verdict();
  end
endmodule
